// [shared/srst_defs.svh]
// constants of the system reset controller
//
// Functional notes
// R01: five reset sources feed one controller
// R02: power-on resets core, peripherals and test port
// R03: pin reset spares test port except pins
// R04: other resets spare test port; peripheral reset selective
// R05: set then clear a bit resets peripheral
// R06: peripheral reset drives all its clock domains
// R07: reset bits follow clock gating bit order
// R08: cause bits are sticky across later resets
// R09: power-on leaves only the power-on cause
// R10: boot fetch after power-on detector drops
// R11: power-on detector acts only at power-up
// R12: pin held low, then release and boot
// R13: brown-out detection off until software enables
// R14: brown-out gives interrupt or reset per config
// R15: brown-out resets only with enable bit set
// R16: brown-out reset held until supply restored
// R17: system reset request resets all, then boots; the test port is not reset
// R18: read-only identification registers for software
// R19: second watchdog timeout with pending interrupt resets
// R20: resets assert at once, release through two stages; test port resets drop one cycle after their source, without the stages
// R21: one cause bit per source, software clears
`ifndef SRST_DEFS_SVH
`define SRST_DEFS_SVH

// register word offsets (byte addresses)
`define SRST_OFS_CAUSE   8'h00
`define SRST_OFS_BORCTL  8'h04
`define SRST_OFS_PRST0   8'h08
`define SRST_OFS_PRST1   8'h0C
`define SRST_OFS_PRST2   8'h10
`define SRST_OFS_CORECTL 8'h14
`define SRST_OFS_IDENTA  8'h18
`define SRST_OFS_IDENTB  8'h1C
`define SRST_OFS_CAPA    8'h20

// field positions
`define SRST_BOR_DET_EN  0
`define SRST_BOR_RST_EN  1
`define SRST_SYSREQ_BIT  2

// reset values
`define SRST_CAUSE_RST   5'h00
`define SRST_CAUSE_POR   5'h02
`define SRST_BORCTL_RST  2'h0

`endif

// [shared/srst_pkg.sv]
// types of the system reset controller
package srst_pkg;

  // register bus request from software
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } srst_bus_s;

  // one sticky bit per reset source
  typedef struct packed {
    logic wdt;
    logic sw;
    logic bor;
    logic por;
    logic ext;
  } srst_cause_s;

  // power-up tracking
  typedef enum logic {
    PH_POWERUP = 1'b0,
    PH_RUN     = 1'b1
  } srst_phase_e;

endpackage : srst_pkg

// [rtl/srst_ctrl.sv]
// system reset controller: sources, routing, cause record, release
`timescale 1ns/100ps
`include "srst_defs.svh"

module srst_ctrl
  import srst_pkg::*;
#(
  parameter int          PW       = 32,  // bits per peripheral reset reg
  parameter int          NDOM     = 2,   // clock domains per peripheral
  parameter logic [31:0] IDENTA_V = 32'h0001_0000, // arbitrary value
  parameter logic [31:0] IDENTB_V = 32'h0002_0000, // arbitrary value
  parameter logic [31:0] CAPA_V   = 32'h0000_00FF  // arbitrary value
) (
  // clock and power-up reset
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  // register bus
  input  wire srst_bus_s          bus_i,
  output logic [31:0]             rdata_o,
  // reset sources
  input  wire logic               rst_pin_n_i,
  input  wire logic               por_det_i,
  input  wire logic               bod_det_i,
  // watchdog events
  input  wire logic               wdt_timeout_i,
  input  wire logic               wdt_int_clr_i,
  input  wire logic               wdt_rst_en_i,
  // reset outputs
  output logic                    core_rst_o,
  output logic                    tap_rst_o,
  output logic                    tap_pin_rst_o,
  output logic [3*PW*NDOM-1:0]    per_rst_o,
  output logic                    boot_fetch_o,
  // interrupts toward the core
  output logic                    bor_int_o,
  output logic                    wdt_int_o
);

  localparam int NPER = 3 * PW;  // peripherals addressed by reset regs

  // refuse register widths the bus cannot carry
  if (PW < 1 || PW > 32 || NDOM < 1) begin : g_bad_param
    $error("srst_ctrl: PW must be 1..32 and NDOM at least 1");
  end

  srst_phase_e       phase;       // power-up or running
  srst_cause_s       cause;       // sticky reset cause
  logic [1:0]        borctl;      // detect enable, reset enable
  logic [NPER-1:0]   prst;        // peripheral reset bits
  logic [NPER-1:0]   prst_q;      // previous value, for fall detect
  logic [1:0]        core_sync;   // release stages
  logic              sw_req;      // one-cycle system request
  logic              por_act;     // power-on reset active
  logic              ext_act;     // pin reset active
  logic              bor_det;     // brown-out seen while enabled
  logic              bor_act;     // brown-out reset active
  logic              wdt_req;     // watchdog reset request
  logic              raw_rst;     // any system-wide reset
  logic              wr_cause;    // write to cause register
  logic [NPER-1:0]   next_prst;   // peripheral bits after a write

  // source decode
  assign por_act  = (phase == PH_POWERUP);                       // R11
  assign ext_act  = !rst_pin_n_i;                                // R03
  assign bor_det  = bod_det_i && borctl[`SRST_BOR_DET_EN];       // R13
  assign bor_act  = bor_det && borctl[`SRST_BOR_RST_EN];         // R15 R16
  assign wdt_req  = wdt_timeout_i && wdt_int_o && wdt_rst_en_i;  // R19
  // every source joins here; peripheral reset stays apart
  assign raw_rst  = por_act | ext_act | bor_act | sw_req | wdt_req; // R01 R04
  assign wr_cause = bus_i.wr && (bus_i.addr == `SRST_OFS_CAUSE);

  // power-up tracking: the detector is obeyed only once
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      phase <= PH_POWERUP;
    end else begin
      unique case (phase)
        PH_POWERUP: begin
          // hold until detector drops, then never look again
          if (!por_det_i) begin
            phase <= PH_RUN; // R10 R11
          end
        end
        PH_RUN: begin
          phase <= PH_RUN;
        end
      endcase
    end
  end

  // release stages: the first stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      core_sync <= 2'h3;
    end else if (raw_rst) begin
      core_sync <= 2'h3; // R20
    end else begin
      core_sync <= {core_sync[0], 1'b0};
    end
  end

  // core reset asserts on the source, drops after the stages drain
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      core_rst_o <= 1'b1;
    end else begin
      core_rst_o <= raw_rst | core_sync[1]; // R17 R20
    end
  end

  // one pulse when the core leaves reset and starts fetching
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      boot_fetch_o <= 1'b0;
    end else begin
      boot_fetch_o <= core_rst_o && !raw_rst && !core_sync[1]; // R10 R12
    end
  end

  // test port: full reset only at power-on, pins also on the pin
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tap_rst_o     <= 1'b1;
      tap_pin_rst_o <= 1'b1;
    end else begin
      tap_rst_o     <= por_act;           // R02 R04
      tap_pin_rst_o <= por_act | ext_act; // R03
    end
  end

  // software system request: self-clearing, stretched by the stages
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sw_req <= 1'b0;
    end else begin
      sw_req <= bus_i.wr && (bus_i.addr == `SRST_OFS_CORECTL)
                && bus_i.wdata[`SRST_SYSREQ_BIT]; // R17
    end
  end

  // brown-out control: off until software turns it on
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || por_act) begin
      borctl <= `SRST_BORCTL_RST; // R13
    end else if (bus_i.wr && bus_i.addr == `SRST_OFS_BORCTL) begin
      borctl <= bus_i.wdata[1:0];
    end
  end

  // brown-out without reset enable becomes an interrupt level
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bor_int_o <= 1'b0;
    end else begin
      bor_int_o <= bor_det && !borctl[`SRST_BOR_RST_EN]; // R14
    end
  end

  // watchdog first timeout pends; a second one resets
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || core_rst_o) begin
      wdt_int_o <= 1'b0;
    end else if (wdt_timeout_i) begin
      wdt_int_o <= 1'b1; // set wins over a clear in the same cycle
    end else if (wdt_int_clr_i) begin
      wdt_int_o <= 1'b0;
    end
  end

  // cause record: sticky, cleared by writing zeros, set wins
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cause <= `SRST_CAUSE_RST;
    end else if (por_act) begin
      cause <= `SRST_CAUSE_POR; // R09
    end else begin
      // a bit clears only when written as zero
      cause <= (wr_cause ? (cause & bus_i.wdata[4:0]) : cause) // R21
             | {wdt_req, sw_req, bor_act, 1'b0, ext_act};       // R08
    end
  end

  // peripheral reset bits: same order as the clock gating bits
  always_comb begin
    next_prst = prst;
    if (bus_i.wr && bus_i.addr == `SRST_OFS_PRST0) begin
      next_prst[PW-1:0] = bus_i.wdata[PW-1:0]; // R07
    end
    if (bus_i.wr && bus_i.addr == `SRST_OFS_PRST1) begin
      next_prst[2*PW-1:PW] = bus_i.wdata[PW-1:0];
    end
    if (bus_i.wr && bus_i.addr == `SRST_OFS_PRST2) begin
      next_prst[3*PW-1:2*PW] = bus_i.wdata[PW-1:0];
    end
  end

  // reset bits clear with the rest of the system
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || core_rst_o) begin
      prst   <= '0;
      prst_q <= '0;
    end else begin
      prst   <= next_prst;
      prst_q <= prst;
    end
  end

  // per peripheral: fall of its bit starts a staged reset pulse
  for (genvar p = 0; p < NPER; p++) begin : g_per
    logic [1:0] hold;  // release stages of this peripheral
    logic       fire;  // set then cleared by software

    assign fire = prst_q[p] && !prst[p]; // R05

    always_ff @(posedge clock_i) begin
      if (sys_rst_i || raw_rst || fire) begin
        hold <= 2'h3; // R04 R20
      end else begin
        hold <= {hold[0], 1'b0};
      end
    end

    // every clock domain of the unit sees the same reset
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        per_rst_o[p*NDOM +: NDOM] <= '1;
      end else begin
        per_rst_o[p*NDOM +: NDOM] <= {NDOM{raw_rst | fire | hold[1]}}; // R06
      end
    end

    // every peripheral is watched, not only the first, so random picks reach it
    a_per_fire: assert property ( // R05
      @(posedge clock_i) disable iff (sys_rst_i)
      fire |=> (&per_rst_o[p*NDOM +: NDOM]) ##1 (&per_rst_o[p*NDOM +: NDOM]))
      else $error("peripheral reset pulse missing");
  end

  // register reads: data only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !bus_i.rd) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      unique case (bus_i.addr)
        `SRST_OFS_CAUSE:   rdata_o <= {27'h0, cause};
        `SRST_OFS_BORCTL:  rdata_o <= {30'h0, borctl};
        `SRST_OFS_PRST0:   rdata_o <= 32'(prst[PW-1:0]);
        `SRST_OFS_PRST1:   rdata_o <= 32'(prst[2*PW-1:PW]);
        `SRST_OFS_PRST2:   rdata_o <= 32'(prst[3*PW-1:2*PW]);
        `SRST_OFS_IDENTA:  rdata_o <= IDENTA_V; // R18
        `SRST_OFS_IDENTB:  rdata_o <= IDENTB_V;
        `SRST_OFS_CAPA:    rdata_o <= CAPA_V;
        // request bit is self-clearing, unmapped reads zero
        default:           rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // a source followed by three quiet cycles
  sequence s_release;
    raw_rst ##1 !raw_rst [*3];
  endsequence

  a_release_boot: assert property ( // R10
    s_release |=> !core_rst_o && boot_fetch_o)
    else $error("core not released with boot pulse");

  a_por_all: assert property ( // R02
    por_act |=> tap_rst_o && core_rst_o && (&per_rst_o))
    else $error("power-on reset did not reach every target");

  a_ext_no_tap: assert property ( // R03
    (phase == PH_RUN && ext_act) |=> core_rst_o && !tap_rst_o && tap_pin_rst_o)
    else $error("pin reset routing wrong");

  a_per_only: assert property ( // R04
    (!raw_rst && !core_sync[1] && !core_rst_o) |=> !core_rst_o && !tap_rst_o)
    else $error("core reset without a system source");

  a_cause_sticky: assert property ( // R08
    (phase == PH_RUN && !wr_cause) |=> ((cause & $past(cause)) == $past(cause)))
    else $error("cause bit lost without a write");

  a_por_cause: assert property ( // R09
    por_act |=> cause == `SRST_CAUSE_POR)
    else $error("power-on cause not exclusive");

  a_por_once: assert property ( // R11
    phase == PH_RUN |=> phase == PH_RUN)
    else $error("power-on detector obeyed after power-up");

  // a low supply without both enables must leave no brown-out cause behind
  a_bor_gate: assert property ( // R15
    (bod_det_i && !(borctl[`SRST_BOR_RST_EN] && borctl[`SRST_BOR_DET_EN]) && !cause.bor)
    |=> !cause.bor)
    else $error("brown-out reset while disabled");

  a_bor_hold: assert property ( // R16
    bor_act |=> core_rst_o && cause.bor)
    else $error("brown-out reset not held");

  a_bor_irq: assert property ( // R14
    (bor_det && !borctl[`SRST_BOR_RST_EN]) |=> bor_int_o && !$past(bor_act))
    else $error("brown-out interrupt missing");

  a_sw_request: assert property ( // R17
    sw_req |=> (core_rst_o && cause.sw) ##1 core_rst_o)
    else $error("system request did not reset");

  a_wdt_second: assert property ( // R19
    (wdt_timeout_i && wdt_int_o && wdt_rst_en_i) |=> core_rst_o && cause.wdt)
    else $error("second watchdog timeout ignored");

endmodule : srst_ctrl

// [sim/srst_core_model.sv]
// partner model: the core side, counting boot fetches
`timescale 1ns/100ps
module srst_core_model (
  // clock
  input  wire logic       clock_i,
  // resets seen by the core
  input  wire logic       core_rst_i,
  input  wire logic       boot_fetch_i,
  // boot record for the bench
  output logic [7:0]      boot_cnt_o,
  output logic            bad_boot_o
);
  logic was_rst;  // core was held in reset last cycle
  initial begin
    boot_cnt_o = 8'h00;
    bad_boot_o = 1'b0;
    was_rst    = 1'b1;
  end
  // a fetch is legal only right after leaving reset; a stray one is flagged
  always @(posedge clock_i) begin
    // a fetch while the core is still held is just as wrong
    if (boot_fetch_i && core_rst_i) begin
      bad_boot_o <= 1'b1;
    end
    if (boot_fetch_i && !core_rst_i) begin
      boot_cnt_o <= boot_cnt_o + 8'h01;
      if (!was_rst) begin
        bad_boot_o <= 1'b1;
      end
    end
    was_rst <= core_rst_i;
  end
endmodule : srst_core_model

// [sim/system_reset_control_tb_top.sv]
// self-checking bench for the system reset controller
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module system_reset_control_tb_top;
  import srst_pkg::*;
  localparam int PW   = 8;  // short regs keep the run small
  localparam int NDOM = 2;
  // identification values owned by the bench; the values are arbitrary
  localparam logic [31:0] ID_A  = 32'h0A5A_0001;
  localparam logic [31:0] ID_B  = 32'h0A5A_0002;
  localparam logic [31:0] CAP_A = 32'h0000_003C;
  logic                 clock_i, sys_rst_i, rst_pin_n, por_det, bod_det;
  logic                 wdt_to, wdt_clr, wdt_en, rd_q, seen, other;
  srst_bus_s            bus;
  logic [31:0]          rdata, exp_v;
  logic                 core_rst, tap_rst, tap_pin_rst, boot_fetch, bor_int, wdt_int;
  logic [3*PW*NDOM-1:0] per_rst;
  logic [7:0]           boots;
  logic                 bad_boot;
  int                   error_cnt, cmp_count, b, p;
  logic [31:0]          exp_q[$];  // expected read data, oldest first
  srst_ctrl #(.PW(PW), .NDOM(NDOM), .IDENTA_V(ID_A), .IDENTB_V(ID_B), .CAPA_V(CAP_A))
    uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .bus_i(bus), .rdata_o(rdata), .rst_pin_n_i(rst_pin_n), .por_det_i(por_det),
    .bod_det_i(bod_det), .wdt_timeout_i(wdt_to), .wdt_int_clr_i(wdt_clr),
    .wdt_rst_en_i(wdt_en), .core_rst_o(core_rst), .tap_rst_o(tap_rst),
    .tap_pin_rst_o(tap_pin_rst), .per_rst_o(per_rst), .boot_fetch_o(boot_fetch),
    .bor_int_o(bor_int), .wdt_int_o(wdt_int));
  srst_core_model core (.clock_i(clock_i), .core_rst_i(core_rst),
    .boot_fetch_i(boot_fetch), .boot_cnt_o(boots), .bad_boot_o(bad_boot));
  // clock at 40 MHz
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // read data stands only in the cycle after the strobe, so look there
  always @(posedge clock_i) rd_q <= bus.rd;
  always @(negedge clock_i) begin
    if (rd_q) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
    bus.rd <= 1'b0;
  endtask : rd
  // bounded wait for the core to leave reset
  task automatic wait_boot();
    int n;
    for (n = 0; n < 60; n++) begin
      @(negedge clock_i);
      if (boot_fetch === 1'b1) return;
    end
    error_cnt++;
    $display("unexpected at %0t: no boot fetch", $time);
    give_verdict();
  endtask : wait_boot
  initial begin
    sys_rst_i = 1'b1;
    rst_pin_n = 1'b1;
    por_det   = 1'b1;
    bod_det   = 1'b0;
    wdt_to    = 1'b0;
    wdt_clr   = 1'b0;
    wdt_en    = 1'b0;
    bus       = '0;
    rd_q      = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'h9F51));
    tick(10);
    sys_rst_i <= 1'b0;
    // detector still high: everything, test port too, stays in reset
    tick(5);
    @(negedge clock_i);
    `CHK({core_rst, tap_rst}, 2'b11)
    @(posedge clock_i);
    por_det <= 1'b0;
    wait_boot();
    rd(8'h00, 32'h02);
    // pin reset spares the test port apart from its pins
    @(posedge clock_i);
    rst_pin_n <= 1'b0;
    tick(3);
    @(negedge clock_i);
    `CHK({core_rst, tap_rst, tap_pin_rst, &per_rst}, 4'b1011)
    @(posedge clock_i);
    rst_pin_n <= 1'b1;
    wait_boot();
    rd(8'h00, 32'h03);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h00);
    // brown-out: off, interrupt only, reset bit alone, then reset
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, i);
      bod_det <= 1'b1;
      tick(12);
      @(negedge clock_i);
      `CHK({core_rst, bor_int}, {i == 3, i == 1})
      @(posedge clock_i);
      bod_det <= 1'b0;
      if (i == 3) wait_boot();
      tick(2);
    end
    rd(8'h00, 32'h04);
    // software system request
    wr(8'h14, 32'h04);
    tick(2);
    @(negedge clock_i);
    `CHK({core_rst, tap_rst}, 2'b10)
    wait_boot();
    rd(8'h00, 32'h0C);
    // watchdog: a cleared first timeout must not lead to reset
    wdt_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      wdt_to  <= (i != 1);
      wdt_clr <= (i == 1);
      @(posedge clock_i);
      wdt_to  <= 1'b0;
      wdt_clr <= 1'b0;
      @(negedge clock_i);
      // the resetting timeout still pends here; core reset clears it an edge later
      `CHK({core_rst, wdt_int}, {i == 3, i != 1})
    end
    wait_boot();
    `CHK(wdt_int, 1'b0)
    rd(8'h00, 32'h1C);
    // one random peripheral per register: set, clear, watch its resets
    for (int r = 0; r < 3; r++) begin
      b = $urandom_range(PW - 1);
      p = r * PW + b;
      wr(8'h08 + 4 * r, 32'h1 << b);
      wr(8'h08 + 4 * r, 32'h0);
      seen  = 1'b0;
      other = 1'b0;
      repeat (8) begin
        @(negedge clock_i);
        seen  |= &per_rst[p*NDOM +: NDOM];
        other |= core_rst | (|(per_rst & ~({NDOM{1'b1}} << (p * NDOM))));
      end
      `CHK({seen, other}, 2'b10)
    end
    // the power-on detector is ignored after power-up
    @(posedge clock_i);
    por_det <= 1'b1;
    tick(5);
    @(negedge clock_i);
    `CHK({core_rst, tap_rst}, 2'b00)
    @(posedge clock_i);
    por_det <= 1'b0;
    rd(8'h18, ID_A);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, ID_A);
    rd(8'h1C, ID_B);
    rd(8'h20, CAP_A);
    rd(8'h40, 32'h0);
    tick(3);
    `CHK({bad_boot, boots}, {1'b0, 8'h05})
    give_verdict();
  end
endmodule : system_reset_control_tb_top
